// >>> src/tau_pkg.sv
// Constants, field layout and modes of the 16-bit waveform timer.
// Assumes APB word access at byte offsets below and a 25 MHz clock.
package tau_pkg;
    localparam int          CNT_W        = 16;
    localparam int          NCH          = 3;
    localparam int          ADDR_W       = 8;
    localparam int          PRESC_W      = 10;
    localparam real         CLK_MHZ      = 25.0;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_COUNT    = 8'h08;
    localparam logic [7:0]  OFS_PERIOD   = 8'h0c;
    localparam logic [7:0]  OFS_PERIOD_BUFFER   = 8'h10;
    localparam logic [7:0]  OFS_CMP0     = 8'h14;
    localparam logic [7:0]  OFS_CBUF0    = 8'h20;
    localparam logic [7:0]  REG_STRIDE   = 8'h04;
    // Control register fields
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_CS_LSB  = 1;
    localparam int          CTRL_WGM_LSB = 4;
    localparam int          CTRL_DIR_BIT = 6;
    localparam int          CTRL_LCK_BIT = 7;
    localparam int          CTRL_EVC_BIT = 8;
    localparam int          CTRL_CHE_LSB = 9;
    // Status register fields, match flags are write-one-to-clear
    localparam int          ST_FLAG_LSB  = 4;
    // Reset values and count landmarks
    localparam logic [15:0] PER_RST      = 16'hffff;
    localparam logic [15:0] CMP_RST      = 16'h0000;
    localparam logic [15:0] BOTTOM       = 16'h0000;
    localparam logic [15:0] MAXVAL       = 16'hffff;
    // Prescaler divide shift per clock select value
    localparam logic [3:0]  PRESC_SHIFT [8] =
        '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha};

    typedef enum logic [1:0] {
        WG_NORMAL,
        WG_FRQ,
        WG_SINGLE,
        WG_DUAL
    } tau_waveform_mode_select_t;
endpackage : tau_pkg

// >>> src/tau_chan_if.sv
// Bundle between the counter core and one compare channel.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface tau_chan_if;
    logic                    tick;
    tau_pkg::tau_waveform_mode_select_t    mode;
    logic [15:0]             count;
    logic [15:0]             top;
    logic [15:0]             cmp;
    logic                    up;
    logic                    wave;
    modport ctl  (output tick, mode, count, top, cmp, up, input wave);
    modport chan (input tick, mode, count, top, cmp, up, output wave);
endinterface : tau_chan_if

// >>> src/tau_prescaler.sv
// Power-of-two clock prescaler producing one-cycle tick pulses.
// Assumes select is quasi-static; a change may shorten one period.
`timescale 1ns/10ps
module tau_prescaler #(
    parameter int W = tau_pkg::PRESC_W
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Control
    input  wire logic       en,
    input  wire logic [2:0] sel,
    // Tick out
    output logic            tick
);
    logic [W-1:0] div_cnt;
    wire  [W-1:0] mask = W'((32'h1 << tau_pkg::PRESC_SHIFT[sel]) - 32'h1);

    // Tick when all selected low bits are ones
    assign tick = en && ((div_cnt & mask) == mask);

    // Held at zero while stopped so a restart begins a full period
    always_ff @(posedge clk) begin
        if (srst || !en) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + W'(1);
        end
    end

    chk_no_divide: assert property (@(posedge clk) disable iff (srst)
        (en && sel == 3'h0) |-> tick)
        else $error("prescaler select zero did not tick every clock");
endmodule : tau_prescaler

// >>> src/tau_channel.sv
// One compare channel: waveform generator for the four count modes.
// Assumes the core presents count, top and compare from flip-flops.
`timescale 1ns/10ps
module tau_channel (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Core side
    tau_chan_if.chan  ch
);
    wire match  = ch.tick && (ch.count == ch.cmp);
    wire at_bot = (ch.count == tau_pkg::BOTTOM);

    // Waveform state changes only on timer ticks, except normal mode forces it low every clock
    always_ff @(posedge clk) begin
        if (srst) begin
            ch.wave <= 1'b0;
        end else begin
            unique case (ch.mode)
                tau_pkg::WG_NORMAL: ch.wave <= 1'b0;
                tau_pkg::WG_FRQ: begin
                    if (match) ch.wave <= ~ch.wave;
                end
                tau_pkg::WG_SINGLE: begin
                    // Match wins over bottom, so compare zero stays low
                    if (match) ch.wave <= 1'b0;
                    else if (ch.tick && at_bot) ch.wave <= 1'b1;
                end
                tau_pkg::WG_DUAL: begin
                    // Match at top sets, so compare equal to top stays high
                    if (match) begin
                        ch.wave <= !at_bot &&
                                   (!ch.up || ch.count == ch.top);
                    end else if (ch.tick && at_bot) begin
                        ch.wave <= 1'b1;
                    end
                end
            endcase
        end
    end

    chk_frq_toggle: assert property (@(posedge clk) disable iff (srst)
        (ch.mode == tau_pkg::WG_FRQ && match) |=> (ch.wave != $past(ch.wave)))
        else $error("frequency output did not toggle on match");
    chk_ss_zero_low: assert property (@(posedge clk) disable iff (srst)
        (ch.mode == tau_pkg::WG_SINGLE && ch.cmp == tau_pkg::BOTTOM
         && $past(ch.mode) == tau_pkg::WG_SINGLE && ch.tick) |=> !ch.wave)
        else $error("single slope compare zero output not low");
endmodule : tau_channel

// >>> src/tau_timer_top.sv
// Top of the 16-bit waveform timer: APB register file, counter core,
// double buffers, match flags and channel outputs.
// Assumes APB master on clk; event input and pins are asynchronous.
`timescale 1ns/10ps
module tau_timer_top #(
    parameter int PRESC_W = tau_pkg::PRESC_W
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Event count input
    input  wire logic        event_in,
    // Waveform pins
    output logic      [2:0]  waveform_output,
    output logic      [2:0]  waveform_output_oe
);
    localparam int N = tau_pkg::NCH;

    // Control state
    logic                 enable;
    logic [2:0]           clock_select_field;
    tau_pkg::tau_waveform_mode_select_t waveform_mode_select;
    logic                 dir_down;
    logic                 update_lock;
    logic                 event_count_enable;
    logic [N-1:0]         channel_output_enable;
    // Count state
    logic [15:0]          counter_value;
    logic                 slope_down;
    logic [15:0]          period_value;
    logic [15:0]          period_buffer;
    logic                 period_buffer_valid;
    logic [15:0]          compare_value [N];
    logic [15:0]          compare_buffer [N];
    logic [N-1:0]         compare_buffer_valid;
    logic [N-1:0]         match_flag;
    // Event synchroniser
    logic                 ev_meta;
    logic                 ev_sync;
    logic                 ev_prev;
    // Combinational next values
    logic [15:0]          next_count;
    logic                 next_slope;

    // APB decode; always ready, so access phase is the only wait
    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire rd_setup = psel && !penable;
    wire hit_ctrl = (paddr == tau_pkg::OFS_CTRL);
    wire hit_stat = (paddr == tau_pkg::OFS_STATUS);
    wire hit_cnt  = (paddr == tau_pkg::OFS_COUNT);
    wire hit_per  = (paddr == tau_pkg::OFS_PERIOD);
    wire hit_pbuf = (paddr == tau_pkg::OFS_PERIOD_BUFFER);
    wire [N-1:0] hit_cmp;
    wire [N-1:0] hit_cbuf;
    wire [15:0]  cmp_or  [N+1];
    wire [15:0]  cbuf_or [N+1];
    assign cmp_or[0]  = 16'h0000;
    assign cbuf_or[0] = 16'h0000;

    // Per-channel address hits and read selection
    for (genvar n = 0; n < N; n++) begin : g_dec
        assign hit_cmp[n]  = (paddr == 8'(tau_pkg::OFS_CMP0
                                        + 8'(n) * tau_pkg::REG_STRIDE));
        assign hit_cbuf[n] = (paddr == 8'(tau_pkg::OFS_CBUF0
                                        + 8'(n) * tau_pkg::REG_STRIDE));
        assign cmp_or[n+1]  = cmp_or[n]  | (hit_cmp[n]  ? compare_value[n]
                                                        : 16'h0000);
        assign cbuf_or[n+1] = cbuf_or[n] | (hit_cbuf[n] ? compare_buffer[n]
                                                        : 16'h0000);
    end

    wire mapped   = hit_ctrl || hit_stat || hit_cnt || hit_per || hit_pbuf
                    || (|hit_cmp) || (|hit_cbuf);
    wire wr_ctrl  = wr && hit_ctrl;
    wire wr_stat  = wr && hit_stat;
    wire wr_count = wr && hit_cnt;
    wire wr_per   = wr && hit_per;
    wire wr_pbuf  = wr && hit_pbuf;
    wire [N-1:0] wr_cmp  = {N{wr}} & hit_cmp;
    wire [N-1:0] wr_cbuf = {N{wr}} & hit_cbuf;

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // Count landmarks
    wire dual      = (waveform_mode_select == tau_pkg::WG_DUAL);
    wire [15:0] top_value = (waveform_mode_select == tau_pkg::WG_FRQ)
                            ? compare_value[0] : period_value;
    wire at_top    = (counter_value == top_value);
    wire at_bottom = (counter_value == tau_pkg::BOTTOM);
    wire at_max    = (counter_value == tau_pkg::MAXVAL);
    wire count_up  = dual ? !slope_down : !dir_down;

    // Tick source: prescaled clock or synchronised event edge
    wire presc_tick;
    wire ev_rise   = ev_sync && !ev_prev;
    wire tick      = enable && (event_count_enable ? ev_rise
                                                   : presc_tick);

    // Update point: bottom in dual slope, otherwise the turn-around
    wire upd_point = dual ? (at_bottom && slope_down)
                          : (count_up ? at_top : at_bottom);
    wire update_ev = tick && upd_point && !update_lock;

    // Read multiplexer, captured in the setup phase
    wire [31:0] ctrl_word = {20'h00000, channel_output_enable,
                             event_count_enable, update_lock, dir_down,
                             waveform_mode_select, clock_select_field,
                             enable};
    wire [31:0] stat_word = {20'h00000, at_max, at_bottom, waveform_output,
                             match_flag, compare_buffer_valid,
                             period_buffer_valid};
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_word :
        hit_stat ? stat_word :
        hit_cnt  ? {16'h0000, counter_value} :
        hit_per  ? {16'h0000, period_value} :
        hit_pbuf ? {16'h0000, period_buffer} :
        {16'h0000, cmp_or[N] | cbuf_or[N]};

    always_ff @(posedge clk) begin
        if (srst) prdata <= 32'h00000000;
        else if (rd_setup) prdata <= rd_mux;
    end

    // Two flops before the edge detector sees the event pin
    always_ff @(posedge clk) begin
        if (srst) begin
            ev_meta <= 1'b0;
            ev_sync <= 1'b0;
            ev_prev <= 1'b0;
        end else begin
            ev_meta <= event_in;
            ev_sync <= ev_meta;
            ev_prev <= ev_sync;
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (srst) begin
            enable                <= 1'b0;
            clock_select_field    <= 3'h0;
            waveform_mode_select  <= tau_pkg::WG_NORMAL;
            dir_down              <= 1'b0;
            update_lock           <= 1'b0;
            event_count_enable    <= 1'b0;
            channel_output_enable <= 3'h0;
        end else if (wr_ctrl) begin
            enable               <= pwdata[tau_pkg::CTRL_EN_BIT];
            clock_select_field   <= pwdata[tau_pkg::CTRL_CS_LSB +: 3];
            waveform_mode_select <= tau_pkg::tau_waveform_mode_select_t'(
                                    pwdata[tau_pkg::CTRL_WGM_LSB +: 2]);
            dir_down             <= pwdata[tau_pkg::CTRL_DIR_BIT];
            update_lock          <= pwdata[tau_pkg::CTRL_LCK_BIT];
            event_count_enable   <= pwdata[tau_pkg::CTRL_EVC_BIT];
            channel_output_enable <= pwdata[tau_pkg::CTRL_CHE_LSB +: 3];
        end
    end

    // Next count: software write beats any count, clear or reload
    always_comb begin
        next_count = counter_value;
        next_slope = dual ? slope_down : 1'b0;
        if (tick) begin
            if (dual) begin
                if (!slope_down) begin
                    if (at_top) begin
                        next_slope = 1'b1;
                        next_count = at_bottom ? counter_value
                                               : counter_value - 16'h0001;
                    end else begin
                        next_count = counter_value + 16'h0001;
                    end
                end else if (at_bottom) begin
                    next_slope = 1'b0;
                    next_count = at_top ? counter_value : 16'h0001;
                end else begin
                    next_count = counter_value - 16'h0001;
                end
            end else if (count_up) begin
                if (at_top) next_count = tau_pkg::BOTTOM;
                else if (at_max) next_count = tau_pkg::BOTTOM;
                else next_count = counter_value + 16'h0001;
            end else begin
                if (at_bottom) next_count = top_value;
                else next_count = counter_value - 16'h0001;
            end
        end
        if (wr_count) next_count = pwdata[15:0];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            counter_value <= tau_pkg::BOTTOM;
            slope_down    <= 1'b0;
        end else begin
            counter_value <= next_count;
            slope_down    <= next_slope;
        end
    end

    // Period and its buffer; direct write wins over the update copy
    always_ff @(posedge clk) begin
        if (srst) begin
            period_value        <= tau_pkg::PER_RST;
            period_buffer       <= tau_pkg::PER_RST;
            period_buffer_valid <= 1'b0;
        end else begin
            if (wr_per) period_value <= pwdata[15:0];
            else if (update_ev && period_buffer_valid)
                period_value <= period_buffer;
            if (wr_pbuf) period_buffer <= pwdata[15:0];
            // A buffer write in the update cycle keeps the flag set
            if (wr_pbuf) period_buffer_valid <= 1'b1;
            else if (update_ev) period_buffer_valid <= 1'b0;
        end
    end

    // Compare registers, buffers, flags and channel generators
    wire [N-1:0] match_now;
    for (genvar n = 0; n < N; n++) begin : g_ch
        tau_chan_if cif ();
        assign match_now[n] = tick && (counter_value == compare_value[n]);

        always_ff @(posedge clk) begin
            if (srst) begin
                compare_value[n]        <= tau_pkg::CMP_RST;
                compare_buffer[n]       <= tau_pkg::CMP_RST;
                compare_buffer_valid[n] <= 1'b0;
                match_flag[n]           <= 1'b0;
            end else begin
                if (wr_cmp[n]) compare_value[n] <= pwdata[15:0];
                else if (update_ev && compare_buffer_valid[n])
                    compare_value[n] <= compare_buffer[n];
                if (wr_cbuf[n]) compare_buffer[n] <= pwdata[15:0];
                if (wr_cbuf[n]) compare_buffer_valid[n] <= 1'b1;
                else if (update_ev) compare_buffer_valid[n] <= 1'b0;
                // Set beats a write-one clear in the same cycle
                match_flag[n] <= match_now[n] || (match_flag[n] &&
                    !(wr_stat && pwdata[tau_pkg::ST_FLAG_LSB + n]));
            end
        end

        assign cif.tick  = tick;
        assign cif.mode  = waveform_mode_select;
        assign cif.count = counter_value;
        assign cif.top   = top_value;
        assign cif.cmp   = compare_value[n];
        assign cif.up    = count_up;

        tau_channel u_chan (
            .clk  (clk),
            .srst (srst),
            .ch   (cif.chan)
        );

        assign waveform_output[n]    = cif.wave;
        // Pin override needs waveform mode and clock counting
        assign waveform_output_oe[n] = channel_output_enable[n]
            && (waveform_mode_select != tau_pkg::WG_NORMAL)
            && !event_count_enable;
    end

    tau_prescaler #(
        .W (PRESC_W)
    ) u_presc (
        .clk  (clk),
        .srst (srst),
        .en   (enable && !event_count_enable),
        .sel  (clock_select_field),
        .tick (presc_tick)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_cnt_write: assert property (
        wr_count |=> counter_value == $past(pwdata[15:0]))
        else $error("counter write not taken at once");
    chk_up_wrap: assert property (
        (tick && !dual && count_up && at_top && !wr_count)
        |=> counter_value == tau_pkg::BOTTOM)
        else $error("counter did not clear after top");
    chk_down_reload: assert property (
        (tick && !dual && !count_up && at_bottom && !wr_count)
        |=> counter_value == $past(top_value))
        else $error("counter did not reload at bottom");
    chk_pbv_set: assert property (
        wr_pbuf |=> period_buffer_valid)
        else $error("period buffer valid not set");
    chk_per_source: assert property (
        !$stable(period_value) |-> ($past(wr_per) || $past(update_ev)))
        else $error("period changed outside write or update");
    chk_lock_hold: assert property (
        (tick && upd_point && update_lock && !wr_per && !wr_cmp[0])
        ##1 !wr_per [*2] |-> $stable(period_value) && $stable(compare_value[0]))
        else $error("locked update changed working registers");
    chk_match_flag: assert property (
        match_now[1] |=> match_flag[1])
        else $error("match flag not set after match");
    chk_pin_gate: assert property (
        (event_count_enable || waveform_mode_select == tau_pkg::WG_NORMAL)
        |-> waveform_output_oe == 3'h0)
        else $error("pin driven outside waveform clock mode");
    chk_idle_hold: assert property (
        (!enable && !wr_count) [*2] |-> $stable(counter_value))
        else $error("counter moved while disabled");
endmodule : tau_timer_top

// >>> bench/tau_event_src.sv
// Event source in place of the event system.
// Assumes the timer synchronises event_in.
`timescale 1ns/10ps
module tau_event_src (
    // Clock and request
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [3:0] n_pulses,
    // Event line
    output logic            event_in,
    output logic            busy
);
    int cnt = 0;
    // Eight-clock slots leave the synchroniser room
    always @(posedge clk) begin
        if (start && cnt == 0)
            cnt <= n_pulses * 8;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign event_in = (cnt % 8) >= 5;
    assign busy     = cnt != 0;
endmodule : tau_event_src

// >>> bench/tau_timer_top_test.sv
// Bench for the waveform timer: APB master, pin sampling.
// Assumes tau_pkg and the design are compiled first.
`timescale 1ns/10ps
module tau_timer_top_test;
    logic        clk = 1'b0;
    logic        srst, psel, penable, pwrite, pready, pslverr, e;
    logic        ev_in, ev_busy, ev_go;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic [2:0]  wo, oe, pv;
    logic [3:0]  ev_n;
    int          n_fail = 0, cmp_count = 0, seed = 32'h2bd55952;
    int          tg, on [3];
    // Design and event partner
    tau_timer_top uut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_in(ev_in),
        .waveform_output(wo), .waveform_output_oe(oe));
    tau_event_src evs (.clk(clk), .start(ev_go), .n_pulses(ev_n),
        .event_in(ev_in), .busy(ev_busy));
    // 25 MHz clock
    initial forever #20 clk = ~clk;
    // Toggles of channel zero in twelve clocks
    function automatic int n_tog(input int c);
        return 12 / (c + 1);
    endfunction : n_tog
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            n_fail++;
            $display("wrong value at %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // Request held until pready is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && n++ < 64);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) n_fail++;
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rd
    // Reprogram while stopped, period before enable
    task automatic setup(input logic [15:0] p, c0, c1, c2, ct);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h0c, {16'h0, p});
        bus(1'b1, 8'h14, {16'h0, c0});
        bus(1'b1, 8'h18, {16'h0, c1});
        bus(1'b1, 8'h1c, {16'h0, c2});
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h00, {16'h0, ct});
    endtask : setup
    // Pins sampled at falling edges, where they are settled
    task automatic watch();
        {tg, on[0], on[1], on[2]} = '0;
        repeat (3) @(negedge clk);
        pv = wo;
        repeat (12) begin
            @(negedge clk);
            tg += int'(wo[0] !== pv[0]);
            pv = wo;
            foreach (on[i]) on[i] += int'(wo[i] === 1'b1);
        end
        @(posedge clk);
    endtask : watch
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        {srst, psel, penable, pwrite, ev_go} = 5'b10000;
        {paddr, pwdata, ev_n} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(8'h0c, 32'hffff);
        rd(8'hfc, 32'h0);
        chk({31'h0, e}, 32'h1);
        bus(1'b1, 8'h08, 32'hffff);
        rd(8'h04, 32'h800);
        r = $random(seed) & 32'hffff;
        bus(1'b1, 8'h08, r);
        rd(8'h08, r);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            setup(16'h5, c[15:0], 16'h0, 16'h0, 16'h211);
            watch();
            chk(tg, n_tog(c));
            chk({29'h0, oe}, 32'h1);
        end
        setup(16'h5, 16'h3, 16'h0, 16'h6, 16'he21);
        watch();
        chk(on[0], 6);
        chk(on[1], 0);
        chk(on[2], 12);
        // Dual slope, top 6: period of twelve ticks fills the window
        setup(16'h6, 16'h3, 16'h0, 16'h6, 16'he31);
        watch();
        chk(on[0], 6);
        chk(on[1], 0);
        chk(on[2], 12);
        setup(16'h5, 16'h3, 16'h0, 16'h6, 16'he21);
        bus(1'b1, 8'h04, 32'h70);
        bus(1'b1, 8'h00, 32'hea1);
        bus(1'b1, 8'h10, 32'h7);
        bus(1'b1, 8'h20, 32'h2);
        watch();
        bus(1'b0, 8'h04, 32'h0);
        chk(q & 32'h73, 32'h33);
        rd(8'h0c, 32'h5);
        bus(1'b1, 8'h00, 32'he21);
        watch();
        rd(8'h0c, 32'h7);
        rd(8'h14, 32'h2);
        bus(1'b0, 8'h04, 32'h0);
        chk(q & 32'hf, 32'h0);
        $display("test waveforms done");
        setup(16'h9, 16'h0, 16'h0, 16'h0, 16'h4f);
        repeat (900) @(posedge clk);
        rd(8'h08, 32'h0);
        repeat (200) @(posedge clk);
        rd(8'h08, 32'h9);
        setup(16'h9, 16'hffff, 16'h0, 16'h0, 16'hf11);
        r = 1 + ($random(seed) & 7);
        ev_n  <= r[3:0];
        ev_go <= 1'b1;
        @(posedge clk);
        ev_go <= 1'b0;
        repeat (80) @(posedge clk);
        chk({29'h0, oe}, 32'h0);
        rd(8'h08, r);
        $display("test counting done");
        close_out();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (10000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule : tau_timer_top_test
